// [logic/quadrature_decoder_pkg.sv]
// constants shared by the quadrature decoder and its helper modules
// assumes a single 25 MHz core clock and a byte-addressed plain register port
package decoder_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_PS      = 40000;  // 25 MHz core clock
  localparam int SAMPLE_BASE_US     = 128;    // period at selection code 0
  localparam int SAMPLE_BASE_CYCLES = (SAMPLE_BASE_US * 1000000) / CLK_PERIOD_PS;
  localparam int LED_UNIT_PS        = 62500;  // one led_on_time step, 62.5 ns
  localparam int SAMPLE_SEL_MAX     = 10;     // highest defined selection code
  localparam int PERIOD_W           = 22;     // holds 3200 << 10 cycles

  // ------------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_FLAGS      = 8'h00;
  localparam logic [7:0] OFS_ENABLES    = 8'h04;
  localparam logic [7:0] OFS_FLAG_CLEAR = 8'h08;
  localparam logic [7:0] OFS_CONTROL    = 8'h0C;
  localparam logic [7:0] OFS_LED_POL    = 8'h10;
  localparam logic [7:0] OFS_LED_TIME   = 8'h14;
  localparam logic [7:0] OFS_SAMPLE_SEL = 8'h18;
  localparam logic [7:0] OFS_VALID_THR  = 8'h1C;
  localparam logic [7:0] OFS_DOUBLE_THR = 8'h20;
  localparam logic [7:0] OFS_IDLE_THR   = 8'h24;
  localparam logic [7:0] OFS_RESULT     = 8'h28;
  localparam logic [7:0] OFS_ACC_CLEAR  = 8'h2C;
  localparam logic [7:0] OFS_VALID_CNT  = 8'h30;
  localparam logic [7:0] OFS_DOUBLE_CNT = 8'h34;
  localparam logic [7:0] OFS_IDLE_CNT   = 8'h38;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int CTRL_ENABLE   = 0;
  localparam int CTRL_DEBOUNCE = 1;
  localparam int CTRL_DIR_POL  = 2;
  localparam int CTRL_LED_EN   = 3;
  localparam int CTRL_W        = 4;

  localparam int FLAG_POS      = 0;
  localparam int FLAG_NEG      = 1;
  localparam int FLAG_DOUBLE   = 2;
  localparam int FLAG_VALID_OV = 3;
  localparam int FLAG_DOUBLE_OV = 4;
  localparam int FLAG_IDLE_OV  = 5;
  localparam int FLAG_W        = 6;

  localparam int CLR_VALID  = 0;
  localparam int CLR_DOUBLE = 1;
  localparam int CLR_IDLE   = 2;

  localparam int LED_TIME_W = 21;
  localparam int THR_W      = 8;
  localparam int VALID_W    = 9;  // two's complement, bit 8 is the sign

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [LED_TIME_W-1:0] LED_TIME_RESET = 21'h0000FF;
  localparam logic [THR_W-1:0]      THR_RESET      = 8'hFF;
  localparam logic [3:0]            SEL_RESET      = 4'h0;

  // ------------------------------------------------------------------
  // last motion result codes
  // ------------------------------------------------------------------
  localparam logic [2:0] RES_NONE   = 3'h0;
  localparam logic [2:0] RES_POS    = 3'h1;
  localparam logic [2:0] RES_DOUBLE = 3'h2;
  localparam logic [2:0] RES_NEG    = 3'h7;

endpackage

// [logic/phase_filter.sv]
// one phase input: three-stage synchroniser followed by a debounce filter
// assumes the raw pin is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module phase_filter
  import decoder_pkg::*;
#(
  parameter int PW = PERIOD_W
) (
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic          pin,
  input  wire logic          debounce_en,
  input  wire logic [PW-1:0] period_cycles,
  output logic               level
);

  logic          sync1;
  logic          sync2;
  logic          sync3;
  logic          sync_level;
  logic [PW-1:0] steady_cnt;

  // ------------------------------------------------------------------
  // synchroniser
  // ------------------------------------------------------------------
  // a change only counts once stages two and three agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1      <= 1'b0;
      sync2      <= 1'b0;
      sync3      <= 1'b0;
      sync_level <= 1'b0;
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3) begin
        sync_level <= sync3;
      end
    end
  end

  // ------------------------------------------------------------------
  // debounce
  // ------------------------------------------------------------------
  // every clock is a sample; a new level must hold a whole sample period
  // before it passes, so shorter pulses never reach the decoder
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      level      <= 1'b0;
      steady_cnt <= '0;
    end else if (!debounce_en) begin
      level      <= sync_level;
      steady_cnt <= '0;
    end else if (sync_level == level) begin
      steady_cnt <= '0;
    end else if (steady_cnt >= period_cycles) begin
      level      <= sync_level;
      steady_cnt <= '0;
    end else begin
      steady_cnt <= steady_cnt + 1'b1;
    end
  end

endmodule
`default_nettype wire

// [logic/sample_timer.sv]
// sample instant generator with the led lead-in window
// assumes period_cycles and led_cycles are held steady while enabled
`timescale 1ns/1ps
`default_nettype none
module sample_timer
  import decoder_pkg::*;
#(
  parameter int PW = PERIOD_W
) (
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic          enable,
  input  wire logic [PW-1:0] period_cycles,
  input  wire logic [PW-1:0] led_cycles,
  output logic               tick,
  output logic               led_window
);

  logic [PW-1:0] remain;

  // ------------------------------------------------------------------
  // down counter
  // ------------------------------------------------------------------
  // restarts from a full period whenever the decoder is off
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      remain <= '0;
    end else if (!enable || remain == '0) begin
      remain <= period_cycles - 1'b1;
    end else begin
      remain <= remain - 1'b1;
    end
  end

  // sample on the last count; the led is lit for the last led_cycles counts
  assign tick       = enable && (remain == '0);
  assign led_window = enable && (remain < led_cycles);

endmodule
`default_nettype wire

// [logic/quadrature_decoder.sv]
// quadrature decoder top: register port, decoding, accumulators, flags, led
// assumes a plain register port with one-cycle strobes and phase pins
// that are asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module quadrature_decoder
  import decoder_pkg::*;
#(
  parameter int BASE_CYCLES = SAMPLE_BASE_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        phase_a,
  input  wire logic        phase_b,
  output logic             irq,
  output logic             led_pin_out,
  output logic             led_pin_oe
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // position of a {B,A} pair on the gray circle 00,01,11,10
  function automatic logic [1:0] gray_pos(input logic [1:0] ba);
    case (ba)
      2'b00:   gray_pos = 2'h0;
      2'b01:   gray_pos = 2'h1;
      2'b11:   gray_pos = 2'h2;
      default: gray_pos = 2'h3;
    endcase
  endfunction

  // one write strobe per register offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic [CTRL_W-1:0]     control;
  logic                  led_polarity;
  logic [LED_TIME_W-1:0] led_on_time;
  logic [3:0]            sample_period_sel;
  logic [THR_W-1:0]      valid_step_threshold;
  logic [THR_W-1:0]      double_step_threshold;
  logic [THR_W-1:0]      idle_sample_threshold;
  logic [FLAG_W-1:0]     interrupt_enables;
  logic [FLAG_W-1:0]     interrupt_flags;
  logic [2:0]            last_motion_result;
  logic [VALID_W-1:0]    valid_step_accumulator;
  logic [THR_W-1:0]      double_transition_accumulator;
  logic [THR_W-1:0]      idle_sample_accumulator;

  logic decoder_enable;
  logic debounce_enable;
  logic direction_polarity;
  logic led_enable;

  assign decoder_enable     = control[CTRL_ENABLE];
  assign debounce_enable    = control[CTRL_DEBOUNCE];
  assign direction_polarity = control[CTRL_DIR_POL];
  assign led_enable         = control[CTRL_LED_EN];

  // software side control; changing the period while enabled is the
  // caller's hazard, the timer simply picks up the new length on reload
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      control               <= '0;
      led_polarity          <= 1'b0;
      led_on_time           <= LED_TIME_RESET;
      sample_period_sel     <= SEL_RESET;
      valid_step_threshold  <= THR_RESET;
      double_step_threshold <= THR_RESET;
      idle_sample_threshold <= THR_RESET;
      interrupt_enables     <= '0;
    end else if (wr) begin
      if (hit(addr, OFS_CONTROL)) begin
        control <= wdata[CTRL_W-1:0];
      end
      if (hit(addr, OFS_LED_POL)) begin
        led_polarity <= wdata[0];
      end
      if (hit(addr, OFS_LED_TIME)) begin
        led_on_time <= wdata[LED_TIME_W-1:0];
      end
      if (hit(addr, OFS_SAMPLE_SEL)) begin
        sample_period_sel <= wdata[3:0];
      end
      if (hit(addr, OFS_VALID_THR)) begin
        valid_step_threshold <= wdata[THR_W-1:0];
      end
      if (hit(addr, OFS_DOUBLE_THR)) begin
        double_step_threshold <= wdata[THR_W-1:0];
      end
      if (hit(addr, OFS_IDLE_THR)) begin
        idle_sample_threshold <= wdata[THR_W-1:0];
      end
      if (hit(addr, OFS_ENABLES)) begin
        interrupt_enables <= wdata[FLAG_W-1:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  logic [3:0]          sel_clamped;
  logic [PERIOD_W-1:0] period_cycles;
  logic [47:0]         led_product;
  logic [PERIOD_W-1:0] led_cycles;
  logic                tick;
  logic                led_window;

  // reserved codes behave as the longest period
  assign sel_clamped   = (sample_period_sel > 4'(SAMPLE_SEL_MAX))
                         ? 4'(SAMPLE_SEL_MAX) : sample_period_sel;
  assign period_cycles = PERIOD_W'(BASE_CYCLES) << sel_clamped;

  // lead time rounds up so the led is never lit for less than asked, except that it is capped at one whole sample period
  assign led_product = (48'(led_on_time) * 48'(LED_UNIT_PS) + 48'(CLK_PERIOD_PS - 1))
                       / 48'(CLK_PERIOD_PS);
  assign led_cycles  = (led_product > 48'(period_cycles)) ? period_cycles
                       : led_product[PERIOD_W-1:0];

  sample_timer #(
    .PW (PERIOD_W)
  ) u_timer (
    .clk           (clk),
    .nrst          (nrst),
    .enable        (decoder_enable),
    .period_cycles (period_cycles),
    .led_cycles    (led_cycles),
    .tick          (tick),
    .led_window    (led_window)
  );

  // ------------------------------------------------------------------
  // phase inputs
  // ------------------------------------------------------------------
  logic [1:0] raw_ba;
  logic [1:0] clean_ba;

  assign raw_ba = {phase_b, phase_a};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_phase
      phase_filter #(
        .PW (PERIOD_W)
      ) u_filter (
        .clk           (clk),
        .nrst          (nrst),
        .pin           (raw_ba[g]),
        .debounce_en   (debounce_enable),
        .period_cycles (period_cycles),
        .level         (clean_ba[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // decoding
  // ------------------------------------------------------------------
  logic [1:0] prev_ba;
  logic       have_prev;
  logic [1:0] step;
  logic       ev_idle;
  logic       ev_double;
  logic       ev_pos;
  logic       ev_neg;

  // distance round the gray circle: 0 idle, 2 double, 1 or 3 one step
  assign step      = gray_pos(clean_ba) - gray_pos(prev_ba);
  assign ev_idle   = tick && have_prev && (step == 2'h0);
  assign ev_double = tick && have_prev && (step == 2'h2);
  assign ev_pos    = tick && have_prev && (step == (direction_polarity ? 2'h3 : 2'h1));
  assign ev_neg    = tick && have_prev && (step == (direction_polarity ? 2'h1 : 2'h3));

  // the first sample after enabling only seeds the previous pair
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_ba   <= 2'b00;
      have_prev <= 1'b0;
    end else if (!decoder_enable) begin
      have_prev <= 1'b0;
    end else if (tick) begin
      prev_ba   <= clean_ba;
      have_prev <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_motion_result <= RES_NONE;
    end else if (ev_pos) begin
      last_motion_result <= RES_POS;
    end else if (ev_neg) begin
      last_motion_result <= RES_NEG;
    end else if (ev_double) begin
      last_motion_result <= RES_DOUBLE;
    end else if (ev_idle) begin
      last_motion_result <= RES_NONE;
    end
  end

  // ------------------------------------------------------------------
  // accumulators
  // ------------------------------------------------------------------
  logic [2:0]         acc_clear;
  logic [VALID_W-1:0] next_valid;
  logic [VALID_W-1:0] valid_mag;
  logic [THR_W-1:0]   next_double;
  logic [THR_W-1:0]   next_idle;

  assign acc_clear = (wr && hit(addr, OFS_ACC_CLEAR)) ? wdata[2:0] : 3'h0;

  // the unsigned counts stop at full scale rather than wrap to zero
  assign next_valid  = ev_pos ? valid_step_accumulator + 1'b1
                     : ev_neg ? valid_step_accumulator - 1'b1
                     : valid_step_accumulator;
  assign valid_mag   = next_valid[VALID_W-1] ? VALID_W'(0) - next_valid : next_valid;
  assign next_double = (double_transition_accumulator == '1)
                       ? double_transition_accumulator
                       : double_transition_accumulator + 1'b1;
  assign next_idle   = (idle_sample_accumulator == '1)
                       ? idle_sample_accumulator : idle_sample_accumulator + 1'b1;

  // a clear write beats a count landing in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      valid_step_accumulator <= '0;
    end else if (acc_clear[CLR_VALID]) begin
      valid_step_accumulator <= '0;
    end else begin
      valid_step_accumulator <= next_valid;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      double_transition_accumulator <= '0;
    end else if (acc_clear[CLR_DOUBLE]) begin
      double_transition_accumulator <= '0;
    end else if (ev_double) begin
      double_transition_accumulator <= next_double;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      idle_sample_accumulator <= '0;
    end else if (acc_clear[CLR_IDLE]) begin
      idle_sample_accumulator <= '0;
    end else if (ev_idle) begin
      idle_sample_accumulator <= next_idle;
    end
  end

  // ------------------------------------------------------------------
  // flags and interrupt
  // ------------------------------------------------------------------
  logic [FLAG_W-1:0] flag_set;
  logic [FLAG_W-1:0] flag_clear;

  // overflows fire on every counted sample that leaves its count above its threshold
  assign flag_set[FLAG_POS]       = ev_pos;
  assign flag_set[FLAG_NEG]       = ev_neg;
  assign flag_set[FLAG_DOUBLE]    = ev_double;
  assign flag_set[FLAG_VALID_OV]  = (ev_pos || ev_neg) && !acc_clear[CLR_VALID]
                                    && (valid_mag > VALID_W'(valid_step_threshold));
  assign flag_set[FLAG_DOUBLE_OV] = ev_double && !acc_clear[CLR_DOUBLE]
                                    && (next_double > double_step_threshold);
  assign flag_set[FLAG_IDLE_OV]   = ev_idle && !acc_clear[CLR_IDLE]
                                    && (next_idle > idle_sample_threshold);

  assign flag_clear = (wr && hit(addr, OFS_FLAG_CLEAR)) ? wdata[FLAG_W-1:0] : '0;

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      interrupt_flags <= '0;
    end else begin
      interrupt_flags <= (interrupt_flags & ~flag_clear) | flag_set;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(interrupt_flags & interrupt_enables);
    end
  end

  // ------------------------------------------------------------------
  // led pin
  // ------------------------------------------------------------------
  // the pin is only claimed while the led is enabled; idle level is unlit
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      led_pin_out <= 1'b0;
      led_pin_oe  <= 1'b0;
    end else begin
      led_pin_oe <= led_enable;
      if (!led_enable) begin
        led_pin_out <= 1'b0;
      end else if (decoder_enable && (debounce_enable || led_window)) begin
        led_pin_out <= led_polarity;
      end else begin
        led_pin_out <= ~led_polarity;
      end
    end
  end

  // ------------------------------------------------------------------
  // read port
  // ------------------------------------------------------------------
  // data stand for exactly one cycle after the read strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= '0;
    end else if (!rd) begin
      rdata <= '0;
    end else begin
      case (addr)
        OFS_FLAGS:      rdata <= 32'(interrupt_flags);
        OFS_ENABLES:    rdata <= 32'(interrupt_enables);
        OFS_CONTROL:    rdata <= 32'(control);
        OFS_LED_POL:    rdata <= 32'(led_polarity);
        OFS_LED_TIME:   rdata <= 32'(led_on_time);
        OFS_SAMPLE_SEL: rdata <= 32'(sample_period_sel);
        OFS_VALID_THR:  rdata <= 32'(valid_step_threshold);
        OFS_DOUBLE_THR: rdata <= 32'(double_step_threshold);
        OFS_IDLE_THR:   rdata <= 32'(idle_sample_threshold);
        OFS_RESULT:     rdata <= 32'(last_motion_result);
        OFS_VALID_CNT:  rdata <= 32'(valid_step_accumulator);
        OFS_DOUBLE_CNT: rdata <= 32'(double_transition_accumulator);
        OFS_IDLE_CNT:   rdata <= 32'(idle_sample_accumulator);
        default:        rdata <= 32'h00000000;
      endcase
    end
  end

endmodule
`default_nettype wire

// [tb/quadrature_decoder_monitor.sv]
// checker for the quadrature decoder register port, interrupt and led pins
// assumes it is bound into quadrature_decoder and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module decoder_monitor
  import decoder_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic        irq,
  input wire logic        led_pin_out,
  input wire logic        led_pin_oe
);
  logic [3:0] ctrl;
  logic [5:0] en;
  logic       pol;
  logic       deb_lit;
  // shadow copies of writable fields; reads and pins are judged against them
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= 4'h0;
      en   <= 6'h0;
      pol  <= 1'b0;
    end else if (wr) begin
      if (addr == OFS_CONTROL) ctrl <= wdata[3:0];
      if (addr == OFS_ENABLES) en <= wdata[5:0];
      if (addr == OFS_LED_POL) pol <= wdata[0];
    end
  end
  assign deb_lit = ctrl[CTRL_ENABLE] & ctrl[CTRL_DEBOUNCE] & ctrl[CTRL_LED_EN];
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_rd(logic [7:0] a);
    rd && addr == a;
  endsequence
  AST_RD_CTRL: assert property (s_rd(OFS_CONTROL) |=> rdata == {28'h0, ctrl})
    else $error("control read back wrong");
  AST_RD_EN: assert property (s_rd(OFS_ENABLES) |=> rdata == {26'h0, en})
    else $error("enable read back wrong");
  AST_RD_WO: assert property (rd && (addr == OFS_FLAG_CLEAR || addr == OFS_ACC_CLEAR)
    |=> rdata == 32'h0) else $error("write-only register read not zero");
  AST_RD_IDLE: assert property (!rd |=> rdata == 32'h0)
    else $error("read data outside read answer");
  AST_OE: assert property (led_pin_oe == $past(ctrl[CTRL_LED_EN]))
    else $error("led enable pin does not follow control");
  AST_LED_OFF: assert property (!led_pin_oe |-> !led_pin_out)
    else $error("led driven while released");
  // debounce keeps the led lit; ctrl and polarity must have settled two cycles
  AST_LED_DEB: assert property ($past(deb_lit) && $past(ctrl, 2) == $past(ctrl) &&
    $past(pol, 2) == $past(pol) |-> led_pin_out == $past(pol)) else $error("led not lit");
  AST_IRQ_MASK: assert property ($past(en) == 6'h0 && $past(en, 2) == 6'h0 |-> !irq)
    else $error("interrupt with all sources masked");
endmodule
bind quadrature_decoder decoder_monitor mon (
  .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .irq(irq), .led_pin_out(led_pin_out), .led_pin_oe(led_pin_oe)
);
`default_nettype wire

// [tb/encoder_model.sv]
// behavioural incremental encoder: phases in gray order, A leads going forward
// assumes the bench pulses step or jump for one clock per movement
`timescale 1ns/1ps
`default_nettype none
module encoder_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic step,
  input wire logic fwd,
  input wire logic jump,
  output logic     phase_a,
  output logic     phase_b
);
  logic [1:0] pos;
  // position on the gray cycle; a jump moves both phases at once (a fault)
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) pos <= 2'h0;
    else if (step) pos <= fwd ? pos + 2'h1 : pos - 2'h1;
    else if (jump) pos <= pos + 2'h2;
  end
  assign phase_a = pos[0] ^ pos[1];
  assign phase_b = pos[1];
endmodule
`default_nettype wire

// [tb/tb.sv]
// self-checking bench: register tasks, encoder moves synced to the led window
// assumes a short base period so each tick is 16 clocks at code 0
`timescale 1ns/1ps
`default_nettype none
module tb;
  import decoder_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, step = 1'b0, fwd = 1'b0, jump = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, got;
  logic phase_a, phase_b, irq, led_pin_out, led_pin_oe;
  int errors = 0, n_tests = 0;
  logic [7:0] ofs [15] = '{OFS_FLAGS, OFS_ENABLES, OFS_FLAG_CLEAR, OFS_CONTROL, OFS_LED_POL,
    OFS_LED_TIME, OFS_SAMPLE_SEL, OFS_VALID_THR, OFS_DOUBLE_THR, OFS_IDLE_THR, OFS_RESULT,
    OFS_VALID_CNT, OFS_DOUBLE_CNT, OFS_IDLE_CNT, 8'h3C};
  logic [31:0] rv [15] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hFF, 32'h0, 32'hFF, 32'hFF,
    32'hFF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  always #20 clk = ~clk;
  quadrature_decoder #(.BASE_CYCLES(16)) dut (.clk(clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .phase_a(phase_a), .phase_b(phase_b),
    .irq(irq), .led_pin_out(led_pin_out), .led_pin_oe(led_pin_oe));
  encoder_model enc (.clk(clk), .nrst(nrst), .step(step), .fwd(fwd), .jump(jump),
    .phase_a(phase_a), .phase_b(phase_b));
  task automatic print_verdict;
    if (errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // every task starts and ends just after a rising edge
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
    chk(got, e);
    @(posedge clk);
  endtask
  task automatic ck_irq(input logic e);
    #1 chk({31'h0, irq}, {31'h0, e});
    @(posedge clk);
  endtask
  // the led goes dark just after each sample, so its falling edge marks a tick
  task automatic tick;
    int i;
    i = 0;
    while (led_pin_out !== 1'b1 && i < 80) begin
      @(negedge clk);
      i++;
    end
    while (led_pin_out !== 1'b0 && i < 80) begin
      @(negedge clk);
      i++;
    end
    if (i >= 80) begin
      errors++;
      print_verdict;
    end
    @(posedge clk);
  endtask
  task automatic mv(input logic s, input logic f, input logic j, input logic [31:0] e);
    step <= s;
    fwd <= f;
    jump <= j;
    @(posedge clk);
    step <= 1'b0;
    jump <= 1'b0;
    tick;
    rchk(OFS_RESULT, e);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int k = 0; k < 15; k++) rchk(ofs[k], rv[k]);
    wreg(OFS_ENABLES, 32'hFFFFFFFF);
    rchk(OFS_ENABLES, 32'h3F);
    wreg(OFS_ENABLES, 32'h0);
    wreg(OFS_VALID_THR, 32'h2);
    wreg(OFS_DOUBLE_THR, 32'h0);
    wreg(OFS_LED_POL, 32'h1);
    wreg(OFS_LED_TIME, 32'h1);
    wreg(OFS_CONTROL, 32'h9);
    tick;
    wreg(OFS_ACC_CLEAR, 32'h7);
    mv(1'b1, 1'b1, 1'b0, 32'h1);
    mv(1'b1, 1'b1, 1'b0, 32'h1);
    mv(1'b1, 1'b1, 1'b0, 32'h1);
    mv(1'b1, 1'b0, 1'b0, 32'h7);
    mv(1'b0, 1'b0, 1'b1, 32'h2);
    mv(1'b0, 1'b0, 1'b0, 32'h0);
    rchk(OFS_IDLE_CNT, 32'h1);
    rchk(OFS_VALID_CNT, 32'h2);
    rchk(OFS_DOUBLE_CNT, 32'h1);
    rchk(OFS_FLAGS, 32'h1F);
    ck_irq(1'b0);
    wreg(OFS_ENABLES, 32'h4);
    ck_irq(1'b1);
    wreg(OFS_FLAG_CLEAR, 32'h4);
    ck_irq(1'b0);
    rchk(OFS_FLAGS, 32'h1B);
    wreg(OFS_CONTROL, 32'hD);
    mv(1'b1, 1'b1, 1'b0, 32'h7);
    rchk(OFS_VALID_CNT, 32'h1);
    wreg(OFS_ACC_CLEAR, 32'h1);
    rchk(OFS_VALID_CNT, 32'h0);
    rchk(OFS_DOUBLE_CNT, 32'h1);
    wreg(OFS_CONTROL, 32'h0);
    wreg(OFS_SAMPLE_SEL, 32'h1);
    rchk(OFS_SAMPLE_SEL, 32'h1);
    wreg(OFS_IDLE_THR, 32'h2);
    wreg(OFS_CONTROL, 32'hB);
    // a 20-clock jump of both phases straddles a tick; the filter must hide it
    repeat (48) @(posedge clk);
    jump <= 1'b1;
    @(posedge clk);
    jump <= 1'b0;
    repeat (19) @(posedge clk);
    jump <= 1'b1;
    @(posedge clk);
    jump <= 1'b0;
    repeat (40) @(posedge clk);
    rchk(OFS_DOUBLE_CNT, 32'h1);
    // a lasting step must get through the filter and count once
    step <= 1'b1;
    fwd <= 1'b1;
    @(posedge clk);
    step <= 1'b0;
    repeat (80) @(posedge clk);
    rchk(OFS_VALID_CNT, 32'h1);
    rchk(OFS_FLAGS, 32'h3B);
    rchk(OFS_CONTROL, 32'hB);
    #1 chk({30'h0, led_pin_oe, led_pin_out}, 32'h3);
    @(posedge clk);
    print_verdict;
  end
endmodule
`default_nettype wire
